/* File: hdl/rtc_cfg.svh */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// Register byte addresses
`define RTC_ADDR_SECONDS 8'h00
`define RTC_ADDR_CONTROL 8'h07
`define RTC_ADDR_TRIM 8'h08
`define RTC_ADDR_ALM0_WKDAY 8'h0d
`define RTC_ADDR_ALM1_WKDAY 8'h14
// Control register fields
`define RTC_CTL_OUT 7
`define RTC_CTL_SQUARE_WAVE_ENABLE 6
`define RTC_CTL_ALARM1_ENABLE 5
`define RTC_CTL_ALARM0_ENABLE 4
`define RTC_CTL_EXTERNAL_CLOCK_INPUT_ENABLE 3
`define RTC_CTL_COARSE 2
`define RTC_CTL_FS_HI 1
`define RTC_CTL_FS_LO 0
`define RTC_CTL_RESET 8'h80
// Trim register fields
`define RTC_TRIM_SIGN 7
`define RTC_TRIM_RESET 8'h00
// Alarm weekday fields
`define RTC_WK_POL 7
`define RTC_WK_FLAG 3
`define RTC_WK_RESET 8'h00
`define RTC_WK_STORE_MASK 8'h77
// Oscillator start value for the seconds register
`define RTC_SECONDS_START 8'h80
// Prescaler and trim timing
`define RTC_PRESC_LAST 15'h7fff
`define RTC_TRIM_POINT 15'h0001
`define RTC_TRIM_POINT_LO 8'h01
`define RTC_SEC_LAST 6'd59
// Calibration arithmetic
`define RTC_CAL_CLK_MIN 40'd1966080
`define RTC_CAL_PPM_DIV 40'd2000000
`define RTC_CAL_FRAC_BITS 6'd11
`define RTC_TRIM_MAX 40'd127
`endif

/* File: hdl/rtc_pkg.sv */
`default_nettype none
package rtc_pkg;
  // Host order codes
  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ = 3'h1,
    OP_CAL_PREP = 3'h2,
    OP_CAL_FREQ = 3'h3,
    OP_CAL_PPM = 3'h4
  } host_op_type;
  // Host sequencer states
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_WRITE = 5'b00010,
    H_RD_WAIT = 5'b00100,
    H_RD_CAP = 5'b01000,
    H_DONE = 5'b10000
  } host_state_type;
endpackage : rtc_pkg
`default_nettype wire

/* File: hdl/rtc_link_if.sv */
`default_nettype none
interface rtc_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic mfp_out;
  logic mfp_oe;
  logic mfp_pin;
  // Open-drain wire with pull-up: high unless the device pulls it
  assign mfp_pin = mfp_oe ? mfp_out : 1'b1;
  modport dev (
    input addr, wdata, wr, rd,
    output rdata, mfp_out, mfp_oe
  );
  modport host (
    output addr, wdata, wr, rd,
    input rdata, mfp_pin
  );
endinterface : rtc_link_if
`default_nettype wire

/* File: hdl/rtc_pin_trim_dev.sv */
`include "rtc_cfg.svh"
`default_nettype none
// Operation
// - Alarm mode when square wave off, alarm on
// - Alarm output keeps working on backup supply
// - Single alarm, polarity 1: pin equals flag
// - Single alarm, polarity 0: pin inverts flag
// - Dual alarm, polarity 1: OR of flags
// - Dual alarm, polarity 0: low only both set
// - All off: pin follows output level bit
// - General output released on backup supply
// - Fine trim adjusts once per minute
// - Sign bit seven adds or subtracts cycles
// - Each step moves two oscillator cycles
// - Step count maps linearly to 2..254 cycles
// - Zero step count disables trimming
// - Coarse trim adjusts 128 times per second
// - Trimming continues on backup supply
// - Host prepares calibration in fixed order
// - Host sign follows error clock polarity
// - Host computes trim from measured frequency
// - Host computes trim from ppm deviation
// - Square wave enable overrides other modes
// - Weekday write clears flag, no software set
module rtc_pin_trim_dev
  import rtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  rtc_link_if.dev link,
  input wire logic osc_tick_i,
  input wire logic alarm0_match_i,
  input wire logic alarm1_match_i,
  input wire logic on_backup_i,
  input wire logic square_wave_i,
  output logic second_tick_o,
  output logic square_wave_enable_o,
  output logic coarse_trim_enable_o,
  output logic external_clock_input_enable_o,
  output logic [1:0] square_wave_freq_select_o
);
  logic [7:0] control_r;
  logic [7:0] oscillator_trim_r;
  logic [7:0] alarm0_weekday_r;
  logic [7:0] alarm1_weekday_r;
  logic alarm_output_polarity_r;
  logic alarm0_match_flag_r;
  logic alarm1_match_flag_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [14:0] presc_r;
  logic [5:0] sec_r;
  logic [7:0] skip_r;
  logic sec_tick_r;
  logic mfp_low_r;
  logic mfp_low_nxt;
  logic wr_control;
  logic wr_trim;
  logic wr_wk0;
  logic wr_wk1;
  logic [7:0] trim_cycles;
  logic trim_on;
  logic at_point;
  logic [15:0] presc_sum;
  logic [7:0] presc_inc;
  logic sel_flag;
  logic alarm_level;
  // Address decode of the write strobe
  assign wr_control = link.wr && (link.addr == `RTC_ADDR_CONTROL);
  assign wr_trim = link.wr && (link.addr == `RTC_ADDR_TRIM);
  assign wr_wk0 = link.wr && (link.addr == `RTC_ADDR_ALM0_WKDAY);
  assign wr_wk1 = link.wr && (link.addr == `RTC_ADDR_ALM1_WKDAY);

  // Control register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      control_r <= `RTC_CTL_RESET;
    end else if (wr_control) begin
      control_r <= link.wdata;
    end
  end

  // Trim register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oscillator_trim_r <= `RTC_TRIM_RESET;
    end else if (wr_trim) begin
      oscillator_trim_r <= link.wdata;
    end
  end

  // Weekday configuration; the flag bit is never stored from software
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm0_weekday_r <= `RTC_WK_RESET;
      alarm1_weekday_r <= `RTC_WK_RESET;
    end else begin
      if (wr_wk0) begin
        alarm0_weekday_r <= link.wdata & `RTC_WK_STORE_MASK;
      end
      if (wr_wk1) begin
        alarm1_weekday_r <= link.wdata & `RTC_WK_STORE_MASK;
      end
    end
  end

  // One polarity bit shared by both weekday registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm_output_polarity_r <= 1'b0;
    end else if (wr_wk0 || wr_wk1) begin
      alarm_output_polarity_r <= link.wdata[`RTC_WK_POL];
    end
  end

  // Match flags: a match in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm0_match_flag_r <= 1'b0;
      alarm1_match_flag_r <= 1'b0;
    end else begin
      if (alarm0_match_i) begin
        alarm0_match_flag_r <= 1'b1;
      end else if (wr_wk0) begin
        alarm0_match_flag_r <= 1'b0;
      end
      if (alarm1_match_i) begin
        alarm1_match_flag_r <= 1'b1;
      end else if (wr_wk1) begin
        alarm1_match_flag_r <= 1'b0;
      end
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (link.addr)
      `RTC_ADDR_CONTROL: rdata_nxt = control_r;
      `RTC_ADDR_TRIM: rdata_nxt = oscillator_trim_r;
      `RTC_ADDR_ALM0_WKDAY: begin
        rdata_nxt = alarm0_weekday_r;
        rdata_nxt[`RTC_WK_POL] = alarm_output_polarity_r;
        rdata_nxt[`RTC_WK_FLAG] = alarm0_match_flag_r;
      end
      `RTC_ADDR_ALM1_WKDAY: begin
        rdata_nxt = alarm1_weekday_r;
        rdata_nxt[`RTC_WK_POL] = alarm_output_polarity_r;
        rdata_nxt[`RTC_WK_FLAG] = alarm1_match_flag_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= link.rd ? rdata_nxt : 8'h00;
    end
  end
  assign link.rdata = rdata_r;

  // Trim amount: two cycles per step, zero means off
  assign trim_cycles = {oscillator_trim_r[6:0], 1'b0};
  assign trim_on = (oscillator_trim_r[6:0] != 7'h00);

  // Fixed adjust point, one per trim period
  always_comb begin
    if (control_r[`RTC_CTL_COARSE]) begin
      at_point = (presc_r[7:0] == `RTC_TRIM_POINT_LO);
    end else begin
      at_point = (presc_r == `RTC_TRIM_POINT) && (sec_r == 6'd0);
    end
  end

  // Add mode jumps the prescaler forward on the point tick
  always_comb begin
    presc_inc = 8'h01;
    if (at_point && trim_on && oscillator_trim_r[`RTC_TRIM_SIGN]) begin
      presc_inc = 8'h01 + trim_cycles;
    end
  end
  assign presc_sum = {1'b0, presc_r} + {8'h00, presc_inc};

  // Subtract mode swallows ticks; backup supply does not stop any of this
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      skip_r <= 8'h00;
    end else if (osc_tick_i) begin
      if (skip_r != 8'h00) begin
        skip_r <= skip_r - 8'h01;
      end else if (at_point && trim_on &&
                   !oscillator_trim_r[`RTC_TRIM_SIGN]) begin
        skip_r <= trim_cycles;
      end
    end
  end

  // Prescaler and minute position; the carry also catches a long add
  // that jumps past the last count, so no second is lost
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_r <= 15'h0000;
      sec_r <= 6'd0;
    end else if (osc_tick_i && (skip_r == 8'h00)) begin
      presc_r <= presc_sum[14:0];
      if (presc_sum[15]) begin
        sec_r <= (sec_r == `RTC_SEC_LAST) ? 6'd0 : sec_r + 6'd1;
      end
    end
  end

  // One-cycle pulse per corrected second
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= osc_tick_i && (skip_r == 8'h00) && presc_sum[15];
    end
  end
  assign second_tick_o = sec_tick_r;

  // Alarm level from the enabled flags and the polarity
  always_comb begin
    sel_flag = control_r[`RTC_CTL_ALARM0_ENABLE] ? alarm0_match_flag_r
                                          : alarm1_match_flag_r;
    if (control_r[`RTC_CTL_ALARM0_ENABLE] && control_r[`RTC_CTL_ALARM1_ENABLE]) begin
      if (alarm_output_polarity_r) begin
        alarm_level = alarm0_match_flag_r | alarm1_match_flag_r;
      end else begin
        alarm_level = !(alarm0_match_flag_r & alarm1_match_flag_r);
      end
    end else if (alarm_output_polarity_r) begin
      alarm_level = sel_flag;
    end else begin
      alarm_level = !sel_flag;
    end
  end

  // Pin mode select; released means the pull-up holds it high
  always_comb begin
    if (control_r[`RTC_CTL_SQUARE_WAVE_ENABLE]) begin
      mfp_low_nxt = !on_backup_i && !square_wave_i;
    end else if (control_r[`RTC_CTL_ALARM0_ENABLE] ||
                 control_r[`RTC_CTL_ALARM1_ENABLE]) begin
      mfp_low_nxt = !alarm_level;
    end else if (on_backup_i) begin
      mfp_low_nxt = 1'b0;
    end else begin
      mfp_low_nxt = !control_r[`RTC_CTL_OUT];
    end
  end

  // Registered pin drive, one cycle behind its cause
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mfp_low_r <= 1'b0;
    end else begin
      mfp_low_r <= mfp_low_nxt;
    end
  end
  assign link.mfp_out = 1'b0;
  assign link.mfp_oe = mfp_low_r;

  // Settings towards the square-wave divider
  assign square_wave_enable_o = control_r[`RTC_CTL_SQUARE_WAVE_ENABLE];
  assign coarse_trim_enable_o = control_r[`RTC_CTL_COARSE];
  assign external_clock_input_enable_o = control_r[`RTC_CTL_EXTERNAL_CLOCK_INPUT_ENABLE];
  assign square_wave_freq_select_o = control_r[`RTC_CTL_FS_HI:`RTC_CTL_FS_LO];
endmodule : rtc_pin_trim_dev
`default_nettype wire

/* File: hdl/rtc_pin_trim_host.sv */
`include "rtc_cfg.svh"
`default_nettype none
module rtc_pin_trim_host
  import rtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  rtc_link_if.host link,
  input wire logic start_i,
  input wire host_op_type op_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] freq_sel_i,
  input wire logic signed [15:0] arg_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic mfp_level_o
);

  host_state_type state_r;
  host_op_type op_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [1:0] fs_r;
  logic signed [15:0] arg_r;
  logic [1:0] step_r;
  logic wr_r;
  logic rd_r;
  logic [7:0] rdata_r;
  logic mfp_s1_r;
  logic mfp_s2_r;
  logic [7:0] step_addr;
  logic [7:0] step_data;
  logic last_step;
  logic [15:0] mag;
  logic [5:0] shift;
  logic [39:0] calc;
  logic [6:0] trim_val;

  // Trim magnitude; output frequencies are powers of two so a shift divides
  always_comb begin
    mag = arg_r[15] ? 16'(-arg_r) : 16'(arg_r);
    case (fs_r)
      2'b00: shift = `RTC_CAL_FRAC_BITS;
      2'b01: shift = `RTC_CAL_FRAC_BITS + 6'd12;
      2'b10: shift = `RTC_CAL_FRAC_BITS + 6'd13;
      default: shift = `RTC_CAL_FRAC_BITS + 6'd15;
    endcase
    if (op_r == OP_CAL_PPM) begin
      calc = (40'(mag) * `RTC_CAL_CLK_MIN) / `RTC_CAL_PPM_DIV;
    end else begin
      calc = (40'(mag) * `RTC_CAL_CLK_MIN) >> shift;
    end
    trim_val = (calc > `RTC_TRIM_MAX) ? 7'h7f : calc[6:0];
  end

  // Write script for each order
  always_comb begin
    step_addr = addr_r;
    step_data = wdata_r;
    last_step = 1'b1;
    case (op_r)
      OP_CAL_PREP: begin
        last_step = (step_r == 2'd3);
        case (step_r)
          2'd0: begin
            step_addr = `RTC_ADDR_TRIM;
            step_data = 8'h00;
          end
          2'd1: begin
            step_addr = `RTC_ADDR_SECONDS;
            step_data = `RTC_SECONDS_START;
          end
          2'd2: begin
            step_addr = `RTC_ADDR_CONTROL;
            step_data = {6'h00, fs_r};
          end
          default: begin
            step_addr = `RTC_ADDR_CONTROL;
            step_data = {6'h00, fs_r};
            step_data[`RTC_CTL_SQUARE_WAVE_ENABLE] = 1'b1;
          end
        endcase
      end
      OP_CAL_FREQ, OP_CAL_PPM: begin
        step_addr = `RTC_ADDR_TRIM;
        step_data = {!arg_r[15] && (arg_r != 16'sd0), trim_val};
      end
      default: begin
        step_addr = addr_r;
        step_data = wdata_r;
      end
    endcase
  end

  // Sequencer; bus signals are registered
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= H_IDLE;
      op_r <= OP_WRITE;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      fs_r <= 2'b00;
      arg_r <= 16'sd0;
      step_r <= 2'd0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      case (state_r)
        H_IDLE: begin
          if (start_i) begin
            op_r <= op_i;
            addr_r <= addr_i;
            wdata_r <= wdata_i;
            fs_r <= freq_sel_i;
            arg_r <= arg_i;
            step_r <= 2'd0;
            if (op_i == OP_READ) begin
              rd_r <= 1'b1;
              state_r <= H_RD_WAIT;
            end else begin
              state_r <= H_WRITE;
            end
          end
        end
        H_WRITE: begin
          wr_r <= 1'b1;
          addr_r <= step_addr;
          wdata_r <= step_data;
          step_r <= step_r + 2'd1;
          if (last_step) begin
            state_r <= H_DONE;
          end
        end
        H_RD_WAIT: state_r <= H_RD_CAP;
        H_RD_CAP: state_r <= H_DONE;
        H_DONE: state_r <= H_IDLE;
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // Read capture in the cycle the data stands
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 8'h00;
    end else if (state_r == H_RD_CAP) begin
      rdata_r <= link.rdata;
    end
  end

  // Pin is asynchronous to us, so two flops before use
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mfp_s1_r <= 1'b1;
      mfp_s2_r <= 1'b1;
    end else begin
      mfp_s1_r <= link.mfp_pin;
      mfp_s2_r <= mfp_s1_r;
    end
  end

  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign link.wr = wr_r;
  assign link.rd = rd_r;
  assign busy_o = (state_r != H_IDLE);
  assign done_o = (state_r == H_DONE);
  assign rdata_o = rdata_r;
  assign mfp_level_o = mfp_s2_r;

endmodule : rtc_pin_trim_host
`default_nettype wire

/* File: tb/rtc_pin_trim_assertions.sv */
`include "rtc_cfg.svh"
`default_nettype none
module rtc_pin_trim_assertions (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic mfp_out,
  input wire logic mfp_oe,
  input wire logic mfp_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl_r;
  logic [7:0] trim_r;
  logic pol_r;
  logic wk_sel;
  logic known;
  logic gpo_high;
  // Shadows built from the bus alone, so no peeking into the device
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_r <= `RTC_CTL_RESET;
      trim_r <= `RTC_TRIM_RESET;
      pol_r <= 1'b0;
    end else if (wr) begin
      if (addr == `RTC_ADDR_CONTROL) ctl_r <= wdata;
      if (addr == `RTC_ADDR_TRIM) trim_r <= wdata;
      if (wk_sel) pol_r <= wdata[`RTC_WK_POL];
    end
  end
  // Decode and mode helpers
  assign wk_sel = addr == `RTC_ADDR_ALM0_WKDAY ||
                  addr == `RTC_ADDR_ALM1_WKDAY;
  assign known = wk_sel || addr == `RTC_ADDR_CONTROL ||
                 addr == `RTC_ADDR_TRIM;
  assign gpo_high = ctl_r[7:4] == 4'h8;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  a_strobe_excl: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_rd_single: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside the answer cycle");
  a_unmapped_zero: assert property (rd && !known |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_readback: assert property
    (rd && addr == `RTC_ADDR_CONTROL |=> rdata == $past(ctl_r))
    else $error("control readback differs");
  a_trim_readback: assert property
    (rd && addr == `RTC_ADDR_TRIM |=> rdata == $past(trim_r))
    else $error("trim readback differs");
  a_pol_shared: assert property
    (rd && wk_sel |=> rdata[`RTC_WK_POL] == $past(pol_r))
    else $error("shared polarity bit differs");
  a_open_drain: assert property (mfp_out == 1'b0)
    else $error("pin driven high");
  a_gpo_high: assert property (gpo_high && $past(gpo_high) |-> mfp_pin)
    else $error("pin low with output level high");
  // Main scenarios seen on the link
  c_ctl_write: cover property (wr && addr == `RTC_ADDR_CONTROL);
  c_pin_pull: cover property ($rose(mfp_oe));
  c_pin_free: cover property ($fell(mfp_oe));
endmodule : rtc_pin_trim_assertions
`default_nettype wire

/* File: tb/rtc_output_pin_and_trim_tb_top.sv */
`include "rtc_cfg.svh"
`default_nettype none
module rtc_output_pin_and_trim_tb_top;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic osc_tick_i = 1'b0;
  logic alarm0_match_i = 1'b0;
  logic alarm1_match_i = 1'b0;
  logic on_backup_i = 1'b0;
  logic square_wave_i = 1'b0;
  host_op_type op_i = OP_WRITE;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [1:0] freq_sel_i = 2'h0;
  logic signed [15:0] arg_i = 16'sh0000;
  logic busy_o, done_o, mfp_level_o, second_tick_o, sqw_en;
  logic [7:0] rdata_o;
  logic [1:0] fs_o;
  int n_mismatch = 0;
  int n_checks = 0;
  rtc_link_if link ();
  rtc_pin_trim_dev i_rtc_pin_trim_dev (.clk_i, .arst_n_i, .link(link),
    .osc_tick_i, .alarm0_match_i, .alarm1_match_i, .on_backup_i,
    .square_wave_i, .second_tick_o, .square_wave_enable_o(sqw_en),
    .coarse_trim_enable_o(), .external_clock_input_enable_o(),
    .square_wave_freq_select_o(fs_o));
  rtc_pin_trim_host i_rtc_pin_trim_host (.clk_i, .arst_n_i, .link(link),
    .start_i, .op_i, .addr_i, .wdata_i, .freq_sel_i, .arg_i, .busy_o,
    .done_o, .rdata_o, .mfp_level_o);
  rtc_pin_trim_assertions i_rtc_pin_trim_assertions (.clk_i, .arst_n_i,
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .mfp_out(link.mfp_out), .mfp_oe(link.mfp_oe),
    .mfp_pin(link.mfp_pin));
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset
  // One host order; the next may start at the edge that ends done
  task automatic op(input host_op_type o, input logic [7:0] a,
                    input logic [7:0] d, input logic signed [15:0] g);
    int k;
    op_i <= o;
    addr_i <= a;
    wdata_i <= d;
    arg_i <= g;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (done_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      complete_run();
    end
  endtask : op
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(OP_WRITE, a, d, 16'sh0000);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(OP_READ, a, 8'h00, 16'sh0000);
    check(rdata_o, e);
  endtask : rd
  // Pin settles after one register stage and the two-flop sync
  task automatic pin(input logic e);
    repeat (4) @(posedge clk_i);
    check(8'(link.mfp_pin), 8'(e));
    check(8'(mfp_level_o), 8'(e));
  endtask : pin
  // Ticks every cycle from a cleared prescaler up to the corrected second
  task automatic measure(input int e);
    int k;
    osc_tick_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (second_tick_o !== 1'b1 && k < 40000);
    osc_tick_i <= 1'b0;
    check(8'(k > e - 4 && k < e + 4), 8'h01);
    if (k >= 40000) complete_run();
  endtask : measure
  initial begin
    int m, i;
    logic pol, f0, f1, raw;
    do_reset();
    rd(`RTC_ADDR_CONTROL, `RTC_CTL_RESET);
    rd(`RTC_ADDR_TRIM, `RTC_TRIM_RESET);
    rd(8'h3f, 8'h00);
    wr(8'h3f, 8'h5a);
    rd(`RTC_ADDR_CONTROL, `RTC_CTL_RESET);
    pin(1'b1);
    wr(`RTC_ADDR_CONTROL, 8'h00);
    pin(1'b0);
    on_backup_i <= 1'b1;
    pin(1'b1);
    on_backup_i <= 1'b0;
    wr(`RTC_ADDR_CONTROL, 8'h70);
    pin(1'b0);
    square_wave_i <= 1'b1;
    pin(1'b1);
    square_wave_i <= 1'b0;
    // Every polarity and flag pair in alarm0, alarm1 and dual modes
    for (m = 1; m < 4; m++) begin
      for (i = 0; i < 8; i++) begin
        pol = i[2];
        f0 = i[1];
        f1 = i[0];
        wr(`RTC_ADDR_CONTROL, 8'(m << 4));
        wr(`RTC_ADDR_ALM0_WKDAY, {pol, 7'h00});
        wr(`RTC_ADDR_ALM1_WKDAY, {pol, 7'h00});
        alarm0_match_i <= f0;
        alarm1_match_i <= f1;
        @(posedge clk_i);
        alarm0_match_i <= 1'b0;
        alarm1_match_i <= 1'b0;
        raw = (m == 1) ? f0 : (m == 2) ? f1 : (pol ? f0 | f1 : f0 & f1);
        pin(pol ? raw : !raw);
      end
    end
    on_backup_i <= 1'b1;
    pin(1'b1);
    // Alarm1 alone with its flag clear must pull low, unlike a release
    wr(`RTC_ADDR_ALM1_WKDAY, 8'h80);
    wr(`RTC_ADDR_CONTROL, 8'h20);
    pin(1'b0);
    alarm1_match_i <= 1'b1;
    @(posedge clk_i);
    alarm1_match_i <= 1'b0;
    pin(1'b1);
    on_backup_i <= 1'b0;
    rd(`RTC_ADDR_ALM0_WKDAY, 8'h88);
    wr(`RTC_ADDR_ALM0_WKDAY, 8'h08);
    rd(`RTC_ADDR_ALM0_WKDAY, 8'h00);
    rd(`RTC_ADDR_ALM1_WKDAY, 8'h08);
    // Host calibration orders at 4.096 kHz output
    freq_sel_i <= 2'b01;
    op(OP_CAL_PREP, 8'h00, 8'h00, 16'sh0000);
    rd(`RTC_ADDR_TRIM, 8'h00);
    rd(`RTC_ADDR_CONTROL, 8'h41);
    check(8'({sqw_en, fs_o}), 8'h05);
    op(OP_CAL_FREQ, 8'h00, 8'h00, -16'sd64);
    rd(`RTC_ADDR_TRIM, 8'((64 * 32768 / 4096 * 60) / (2 * 1024)));
    op(OP_CAL_PPM, 8'h00, 8'h00, 16'sd100);
    rd(`RTC_ADDR_TRIM, 8'h80 | 8'(100 * 32768 * 60 / 2000000));
    // Coarse trim adding the largest step per point, on backup supply
    wr(`RTC_ADDR_CONTROL, 8'h04);
    wr(`RTC_ADDR_TRIM, 8'hff);
    on_backup_i <= 1'b1;
    measure(32768 - 128 * 2 * 127);
    on_backup_i <= 1'b0;
    // Coarse trim swallowing 32 cycles per point
    wr(`RTC_ADDR_TRIM, 8'h10);
    measure(32768 + 128 * 2 * 16);
    // Reset again so the prescaler starts clear; zero step means no trim
    do_reset();
    wr(`RTC_ADDR_CONTROL, 8'h04);
    wr(`RTC_ADDR_TRIM, 8'h80);
    measure(32768);
    complete_run();
  end
endmodule : rtc_output_pin_and_trim_tb_top
`default_nettype wire
